// >>> cycle_timing_defs.svh
`ifndef CYCLE_TIMING_DEFS_SVH
`define CYCLE_TIMING_DEFS_SVH

// ----------------------------------------------------------------
// Field widths
// ----------------------------------------------------------------
`define CLK_W          10
`define CNT_W          6
`define REGN_W         5

// ----------------------------------------------------------------
// Last phase number of a bus cycle; a cycle without wait states is four clocks
// ----------------------------------------------------------------
`define BUS_CYCLE_CLKS 2'h3
`define RESULT_RST     '{10'h000, 6'h00, 6'h00}

// ----------------------------------------------------------------
// Costs as {clocks, reads, writes}
// ----------------------------------------------------------------
`define C_COND_TAKEN   '{10'h00A, 6'h02, 6'h00}
`define C_COND_NT_BYTE '{10'h008, 6'h01, 6'h00}
`define C_COND_NT_WORD '{10'h00C, 6'h02, 6'h00}
`define C_BRANCH_ALW   '{10'h00A, 6'h02, 6'h00}
`define C_BRANCH_SUB   '{10'h012, 6'h02, 6'h02}
`define C_DEC_TRUE     '{10'h00C, 6'h02, 6'h00}
`define C_DEC_TAKEN    '{10'h00A, 6'h02, 6'h00}
`define C_DEC_EXPIRED  '{10'h00E, 6'h03, 6'h00}
`define C_SW_VECTOR    '{10'h022, 6'h04, 6'h03}
`define C_OVF_TAKEN    '{10'h022, 6'h05, 6'h03}
`define C_OVF_NT       '{10'h004, 6'h01, 6'h00}
`define C_JUMP_IND     '{10'h008, 6'h02, 6'h00}
`define C_JUMP_DISP    '{10'h00A, 6'h02, 6'h00}
`define C_JUMP_IDX     '{10'h00E, 6'h02, 6'h00}
`define C_JUMP_ABSL    '{10'h00C, 6'h03, 6'h00}
`define C_JUMP_PCIDX   '{10'h00E, 6'h03, 6'h00}
`define C_ADR_IND      '{10'h004, 6'h01, 6'h00}
`define C_ADR_DISP     '{10'h008, 6'h02, 6'h00}
`define C_ADR_IDX      '{10'h00C, 6'h02, 6'h00}
`define C_ADR_ABSL     '{10'h00C, 6'h03, 6'h00}
`define C_PUSH_EXTRA   '{10'h008, 6'h00, 6'h02}
`define C_MMR_IND      '{10'h00C, 6'h03, 6'h00}
`define C_MMR_DISP     '{10'h010, 6'h04, 6'h00}
`define C_MMR_IDX      '{10'h012, 6'h04, 6'h00}
`define C_MMR_ABSL     '{10'h014, 6'h05, 6'h00}
`define C_MMR_PER_W    '{10'h004, 6'h01, 6'h00}
`define C_MMR_PER_L    '{10'h008, 6'h02, 6'h00}
`define C_RMM_IND      '{10'h008, 6'h02, 6'h00}
`define C_RMM_DISP     '{10'h00C, 6'h03, 6'h00}
`define C_RMM_IDX      '{10'h00E, 6'h03, 6'h00}
`define C_RMM_ABSL     '{10'h010, 6'h04, 6'h00}
`define C_RMM_PER_W    '{10'h005, 6'h00, 6'h01}
`define C_RMM_PER_L    '{10'h00A, 6'h00, 6'h02}
`define C_EXT_REG_BW   '{10'h004, 6'h01, 6'h00}
`define C_EXT_REG_L    '{10'h008, 6'h01, 6'h00}
`define C_EXT_MEM_BW   '{10'h012, 6'h03, 6'h01}
`define C_EXT_MEM_L    '{10'h01E, 6'h05, 6'h02}
`define C_MCMP_BW      '{10'h00C, 6'h03, 6'h00}
`define C_MCMP_L       '{10'h014, 6'h05, 6'h00}
`define C_DEC_REG      '{10'h006, 6'h01, 6'h00}
`define C_STATUS_IMM   '{10'h014, 6'h03, 6'h00}
`define C_LOAD_STATUS  '{10'h00C, 6'h02, 6'h00}
`define C_RETURN       '{10'h010, 6'h04, 6'h00}
`define C_HALT         '{10'h004, 6'h00, 6'h00}
`define C_PMOVE_RM_W   '{10'h010, 6'h02, 6'h02}
`define C_PMOVE_RM_L   '{10'h018, 6'h02, 6'h04}
`define C_PMOVE_MR_W   '{10'h010, 6'h04, 6'h00}
`define C_PMOVE_MR_L   '{10'h018, 6'h06, 6'h00}
`define C_EXC_FAULT    '{10'h032, 6'h04, 6'h07}
`define C_EXC_INT      '{10'h02C, 6'h05, 6'h03}
`define C_EXC_SIMPLE   '{10'h022, 6'h04, 6'h03}

`endif

// >>> cycle_timing_pkg.sv
`include "cycle_timing_defs.svh"

package cycle_timing_pkg;

	typedef enum logic [4:0] {
		OP_COND_BRANCH  = 5'h00, OP_BRANCH_ALWAYS = 5'h01, OP_BRANCH_TO_SUB = 5'h02,
		OP_DEC_BRANCH   = 5'h03, OP_SW_VECTOR     = 5'h04, OP_OVERFLOW_CALL = 5'h05,
		OP_JUMP         = 5'h06, OP_SUB_JUMP      = 5'h07, OP_ADDR_LOAD     = 5'h08,
		OP_ADDR_PUSH    = 5'h09, OP_MULTI_MOVE    = 5'h0A, OP_EXT_ADD       = 5'h0B,
		OP_EXT_SUB      = 5'h0C, OP_MEM_COMPARE   = 5'h0D, OP_DEC_ADD       = 5'h0E,
		OP_DEC_SUB      = 5'h0F, OP_STATUS_AND    = 5'h10, OP_STATUS_XOR    = 5'h11,
		OP_STATUS_OR    = 5'h12, OP_LOAD_STATUS   = 5'h13, OP_SUB_RETURN    = 5'h14,
		OP_HALT_WAIT    = 5'h15, OP_PERIPH_MOVE   = 5'h16, OP_EXC_ADDRESS   = 5'h17,
		OP_EXC_BUS      = 5'h18, OP_EXC_INTERRUPT = 5'h19, OP_EXC_ILLEGAL   = 5'h1A,
		OP_EXC_PRIVILEGE = 5'h1B, OP_EXC_TRACE    = 5'h1C
	} op_e;

	typedef enum logic [3:0] {
		AM_REG_DIRECT = 4'h0, AM_IND       = 4'h1, AM_POSTINC   = 4'h2,
		AM_PREDEC     = 4'h3, AM_DISP      = 4'h4, AM_INDEXED   = 4'h5,
		AM_ABS_SHORT  = 4'h6, AM_ABS_LONG  = 4'h7, AM_PC_DISP   = 4'h8,
		AM_PC_INDEXED = 4'h9
	} mode_e;

	typedef struct packed {
		logic [`CLK_W-1:0] clocks;
		logic [`CNT_W-1:0] reads;
		logic [`CNT_W-1:0] writes;
	} cost_s;

	typedef struct packed {
		op_e                op;
		mode_e              mode;
		logic               size_long;
		logic               disp_word;
		logic               cond_true;
		logic               count_expired;
		logic               to_memory;
		logic               index_long;
		logic [`REGN_W-1:0] reg_count;
		cost_s              ea_cost;
	} instr_req_s;

endpackage

// >>> pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	// Pins in, synchronised out
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// Only the second stage is visible to logic
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pin_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule // pin_sync

`default_nettype wire

// >>> bus_cycle_slot.sv
`timescale 1ns/1ps
`default_nettype none

`include "cycle_timing_defs.svh"

module bus_cycle_slot (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// Sequencer side
	input  wire logic run_i,
	input  wire logic ack_i,
	output logic      last_o,
	output logic      wait_o
);

	logic [1:0] phase_q;

	// ----------------------------------------------------------------
	// Four-phase bus cycle
	// ----------------------------------------------------------------
	// Holding the last phase until the acknowledge is the wait state
	assign last_o = run_i && (phase_q == `BUS_CYCLE_CLKS) && ack_i;
	assign wait_o = run_i && (phase_q == `BUS_CYCLE_CLKS) && !ack_i;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			phase_q <= 2'h0;
		end else if (!run_i || last_o) begin
			phase_q <= 2'h0;
		end else if (phase_q != `BUS_CYCLE_CLKS) begin
			phase_q <= phase_q + 2'h1;
		end
	end

endmodule // bus_cycle_slot

`default_nettype wire

// >>> instruction_cycle_timing.sv
`timescale 1ns/1ps
`default_nettype none

`include "cycle_timing_defs.svh"

module instruction_cycle_timing
	import cycle_timing_pkg::*;
(
	// Clock and reset
	input  wire logic                        core_clk_i,
	input  wire logic                        rst_i,
	// Instruction request
	input  wire logic                        req_valid_i,
	output logic                             req_ready_o,
	input  wire cycle_timing_pkg::instr_req_s req_i,
	// External bus
	output logic                             bus_rd_o,
	output logic                             bus_wr_o,
	output logic                             int_ack_cycle_o,
	input  wire logic                        bus_ack_pin_i,
	// Halt control
	output logic                             halted_o,
	input  wire logic                        resume_pin_i,
	// Completion report
	output logic                             done_o,
	output cycle_timing_pkg::cost_s          result_o
);

	import cycle_timing_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_BUS      = 2'b01,
		ST_INTERNAL = 2'b10,
		ST_HALT     = 2'b11
	} seq_state_e;

	// ----------------------------------------------------------------
	// Cost arithmetic helpers
	// ----------------------------------------------------------------
	function automatic cost_s cost_add(input cost_s a, input cost_s b);
		cost_s s;
		s.clocks = a.clocks + b.clocks;
		s.reads  = a.reads + b.reads;
		s.writes = a.writes + b.writes;
		return s;
	endfunction

	function automatic cost_s cost_scale(input cost_s a, input logic [`REGN_W-1:0] n);
		cost_s s;
		s.clocks = a.clocks * {5'h00, n};
		s.reads  = a.reads * {1'b0, n};
		s.writes = a.writes * {1'b0, n};
		return s;
	endfunction

	// Group of modes sharing one cost column
	function automatic logic [1:0] mode_group(input mode_e m);
		logic [1:0] g;
		case (m)
			AM_DISP, AM_ABS_SHORT, AM_PC_DISP: g = 2'h1;
			AM_INDEXED, AM_PC_INDEXED:         g = 2'h2;
			AM_ABS_LONG:                       g = 2'h3;
			default:                           g = 2'h0;
		endcase
		return g;
	endfunction

	// ----------------------------------------------------------------
	// Cost lookup
	// ----------------------------------------------------------------
	function automatic cost_s base_cost(input instr_req_s r);
		cost_s      c;
		cost_s      jump_c;
		cost_s      adr_c;
		cost_s      mmr_c;
		cost_s      rmm_c;
		logic [1:0] g;
		g = mode_group(r.mode);
		case (g)
			2'h1: begin
				jump_c = `C_JUMP_DISP;
				adr_c = `C_ADR_DISP;
				mmr_c = `C_MMR_DISP;
				rmm_c = `C_RMM_DISP;
			end
			2'h2: begin
				jump_c = `C_JUMP_IDX;
				adr_c = `C_ADR_IDX;
				mmr_c = `C_MMR_IDX;
				rmm_c = `C_RMM_IDX;
			end
			2'h3: begin
				jump_c = `C_JUMP_ABSL;
				adr_c = `C_ADR_ABSL;
				mmr_c = `C_MMR_ABSL;
				rmm_c = `C_RMM_ABSL;
			end
			default: begin
				jump_c = `C_JUMP_IND;
				adr_c = `C_ADR_IND;
				mmr_c = `C_MMR_IND;
				rmm_c = `C_RMM_IND;
			end
		endcase
		case (r.op)
			OP_COND_BRANCH: begin
				if (r.cond_true)
					c = `C_COND_TAKEN;
				else if (r.disp_word)
					c = `C_COND_NT_WORD;
				else
					c = `C_COND_NT_BYTE;
			end
			OP_BRANCH_ALWAYS: c = `C_BRANCH_ALW;
			OP_BRANCH_TO_SUB: c = `C_BRANCH_SUB;
			OP_DEC_BRANCH: begin
				if (r.cond_true)
					c = `C_DEC_TRUE;
				else if (r.count_expired)
					c = `C_DEC_EXPIRED;
				else
					c = `C_DEC_TAKEN;
			end
			OP_SW_VECTOR:     c = `C_SW_VECTOR;
			OP_OVERFLOW_CALL: c = r.cond_true ? `C_OVF_TAKEN : `C_OVF_NT;
			OP_JUMP: c = (r.mode == AM_PC_INDEXED) ? `C_JUMP_PCIDX : jump_c;
			OP_SUB_JUMP: c = cost_add(jump_c, `C_PUSH_EXTRA);
			OP_ADDR_LOAD: c = adr_c;
			OP_ADDR_PUSH: c = cost_add(adr_c, `C_PUSH_EXTRA);
			OP_MULTI_MOVE: begin
				if (r.to_memory)
					c = cost_add(rmm_c, cost_scale(r.size_long ? `C_RMM_PER_L
						: `C_RMM_PER_W, r.reg_count));
				else
					c = cost_add(mmr_c, cost_scale(r.size_long ? `C_MMR_PER_L
						: `C_MMR_PER_W, r.reg_count));
			end
			OP_EXT_ADD, OP_EXT_SUB: begin
				if (r.mode == AM_REG_DIRECT)
					c = r.size_long ? `C_EXT_REG_L : `C_EXT_REG_BW;
				else
					c = r.size_long ? `C_EXT_MEM_L : `C_EXT_MEM_BW;
			end
			OP_MEM_COMPARE: c = r.size_long ? `C_MCMP_L : `C_MCMP_BW;
			OP_DEC_ADD, OP_DEC_SUB:
				c = (r.mode == AM_REG_DIRECT) ? `C_DEC_REG : `C_EXT_MEM_BW;
			OP_STATUS_AND, OP_STATUS_XOR, OP_STATUS_OR: c = `C_STATUS_IMM;
			OP_LOAD_STATUS: c = `C_LOAD_STATUS;
			OP_SUB_RETURN:  c = `C_RETURN;
			OP_HALT_WAIT: c = `C_HALT;
			OP_PERIPH_MOVE: begin
				if (r.to_memory)
					c = r.size_long ? `C_PMOVE_RM_L : `C_PMOVE_RM_W;
				else
					c = r.size_long ? `C_PMOVE_MR_L : `C_PMOVE_MR_W;
			end
			OP_EXC_ADDRESS, OP_EXC_BUS: c = `C_EXC_FAULT;
			OP_EXC_INTERRUPT: c = `C_EXC_INT;
			default: c = `C_EXC_SIMPLE;
		endcase
		if (r.op == OP_LOAD_STATUS && r.mode != AM_REG_DIRECT)
			c = cost_add(c, r.ea_cost);
		return c;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pins_sync;

	pin_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.core_clk_i(core_clk_i),
		.rst_i     (rst_i),
		.pin_i     ({resume_pin_i, bus_ack_pin_i}),
		.sync_o    (pins_sync)
	);

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	seq_state_e         state_q;
	cost_s              req_cost;
	logic [`CLK_W-1:0]  bus_clks;
	logic [`CLK_W-1:0]  internal_d;
	logic [`CNT_W-1:0]  reads_left_q;
	logic [`CNT_W-1:0]  writes_left_q;
	logic [`CLK_W-1:0]  internal_q;
	logic               halt_after_q;
	logic               first_read_q;
	logic               int_entry_q;
	cost_s              used_q;
	cost_s              result_q;
	logic               done_q;
	logic               accept;
	logic               bus_run;
	logic               bus_last;
	logic               bus_is_write;
	logic               last_bus;
	logic               finish;

	assign req_cost   = base_cost(req_i);
	assign bus_clks   = ({4'h0, req_cost.reads} + {4'h0, req_cost.writes}) << 2;
	// Saturate so an odd cost can never underflow the count
	assign internal_d = (req_cost.clocks > bus_clks) ? req_cost.clocks - bus_clks
		: '0;

	assign req_ready_o  = (state_q == ST_IDLE);
	assign accept       = req_ready_o && req_valid_i;
	assign bus_run      = (state_q == ST_BUS);
	// Reads go out before writes
	assign bus_is_write = (reads_left_q == '0);
	assign last_bus     = bus_last && ((bus_is_write ? writes_left_q
		: reads_left_q + writes_left_q) == `CNT_W'(1));

	bus_cycle_slot u_bus_cycle_slot (
		.core_clk_i(core_clk_i),
		.rst_i     (rst_i),
		.run_i     (bus_run),
		.ack_i     (pins_sync[0]),
		.last_o    (bus_last),
		.wait_o    ()
	);

	assign finish = (state_q == ST_INTERNAL && internal_q == `CLK_W'(1) && !halt_after_q)
		|| (last_bus && internal_q == '0 && !halt_after_q)
		|| (state_q == ST_HALT && pins_sync[1]);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (accept)
						state_q <= ({req_cost.reads, req_cost.writes} != '0) ? ST_BUS
							: ST_INTERNAL;
				end
				ST_BUS: begin
					if (last_bus)
						state_q <= (internal_q != '0) ? ST_INTERNAL
							: (halt_after_q ? ST_HALT : ST_IDLE);
				end
				ST_INTERNAL: begin
					if (internal_q == `CLK_W'(1))
						state_q <= halt_after_q ? ST_HALT : ST_IDLE;
				end
				ST_HALT: begin
					if (pins_sync[1])
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Remaining bus cycles
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			reads_left_q  <= '0;
			writes_left_q <= '0;
			first_read_q  <= 1'b0;
		end else if (accept) begin
			reads_left_q  <= req_cost.reads;
			writes_left_q <= req_cost.writes;
			first_read_q  <= 1'b1;
		end else if (bus_last) begin
			first_read_q <= 1'b0;
			if (bus_is_write)
				writes_left_q <= writes_left_q - `CNT_W'(1);
			else
				reads_left_q <= reads_left_q - `CNT_W'(1);
		end
	end

	// Internal clocks and request attributes
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			internal_q   <= '0;
			halt_after_q <= 1'b0;
			int_entry_q  <= 1'b0;
		end else if (accept) begin
			internal_q   <= internal_d;
			halt_after_q <= (req_i.op == OP_HALT_WAIT);
			int_entry_q  <= (req_i.op == OP_EXC_INTERRUPT);
		end else if (state_q == ST_INTERNAL && internal_q != '0) begin
			internal_q <= internal_q - `CLK_W'(1);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			used_q <= `RESULT_RST;
		end else if (accept) begin
			used_q <= `RESULT_RST;
		end else if (state_q == ST_BUS || state_q == ST_INTERNAL) begin
			used_q.clocks <= used_q.clocks + `CLK_W'(1);
			if (bus_last && bus_is_write)
				used_q.writes <= used_q.writes + `CNT_W'(1);
			if (bus_last && !bus_is_write)
				used_q.reads <= used_q.reads + `CNT_W'(1);
		end
	end

	// Completion report
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			done_q   <= 1'b0;
			result_q <= `RESULT_RST;
		end else begin
			done_q <= finish;
			if (state_q == ST_HALT) begin
				result_q <= used_q;
			end else if (finish) begin
				result_q.clocks <= used_q.clocks + `CLK_W'(1);
				result_q.reads  <= used_q.reads + {5'h00, bus_last && !bus_is_write};
				result_q.writes <= used_q.writes + {5'h00, bus_last && bus_is_write};
			end
		end
	end

	assign bus_rd_o        = bus_run && !bus_is_write;
	assign bus_wr_o        = bus_run && bus_is_write;
	assign int_ack_cycle_o = bus_run && int_entry_q && first_read_q;
	assign halted_o        = (state_q == ST_HALT);
	assign done_o          = done_q;
	assign result_o        = result_q;

endmodule // instruction_cycle_timing

`default_nettype wire

// >>> instruction_cycle_timing_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module instruction_cycle_timing_asserts
	import cycle_timing_pkg::*;
(
	// Clock and reset
	input wire logic	core_clk_i,
	input wire logic	rst_i,
	// Request
	input wire logic	req_valid_i,
	input wire logic	req_ready_o,
	input wire cycle_timing_pkg::instr_req_s	req_i,
	// Bus and halt
	input wire logic	bus_rd_o,
	input wire logic	bus_wr_o,
	input wire logic	int_ack_cycle_o,
	input wire logic	bus_ack_pin_i,
	input wire logic	halted_o,
	input wire logic	resume_pin_i,
	// Completion
	input wire logic	done_o,
	input wire cycle_timing_pkg::cost_s	result_o
);
	// ----------------------------------------
	// Request capture and cycle count
	// ----------------------------------------
	logic		busy_q;
	instr_req_s	rq_q;
	logic [9:0]	cyc_q;
	logic		fin;
	assign fin = done_o & busy_q;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			busy_q <= 1'b0;
			rq_q <= '0;
			cyc_q <= 10'h000;
		end else if (req_valid_i && req_ready_o) begin
			busy_q <= 1'b1;
			rq_q <= req_i;
			cyc_q <= 10'h000;
		end else if (done_o) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			cyc_q <= cyc_q + 10'h001;
		end
	end

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	property p_taken;
		fin && rq_q.op == OP_COND_BRANCH && rq_q.cond_true |->
			result_o.reads == 6'h02 && result_o.writes == 6'h00;
	endproperty
	a_taken: assert property (p_taken) else $error("taken branch bus count");
	property p_sub_branch;
		fin && rq_q.op == OP_BRANCH_TO_SUB |->
			result_o.reads == 6'h02 && result_o.writes == 6'h02;
	endproperty
	a_sub_branch: assert property (p_sub_branch) else $error("subroutine branch bus count");
	property p_move;
		fin && rq_q.op == OP_MULTI_MOVE && rq_q.to_memory |->
			result_o.writes == ({1'b0, rq_q.reg_count} << rq_q.size_long);
	endproperty
	a_move: assert property (p_move) else $error("multi move write count");
	property p_status;
		fin && rq_q.op inside {OP_STATUS_AND, OP_STATUS_XOR, OP_STATUS_OR} |->
			result_o.reads == 6'h03 && result_o.writes == 6'h00;
	endproperty
	a_status: assert property (p_status) else $error("status op bus count");
	property p_halt;
		halted_o |-> !bus_rd_o && !bus_wr_o && !req_ready_o;
	endproperty
	a_halt: assert property (p_halt) else $error("bus or ready while halted");
	property p_halt_res;
		fin && rq_q.op == OP_HALT_WAIT |-> result_o == {10'h004, 12'h000};
	endproperty
	a_halt_res: assert property (p_halt_res) else $error("halt result");
	property p_sum;
		fin && rq_q.op != OP_HALT_WAIT |-> result_o.clocks == cyc_q;
	endproperty
	a_sum: assert property (p_sum) else $error("reported clocks differ");
	property p_fault;
		fin && rq_q.op inside {OP_EXC_ADDRESS, OP_EXC_BUS} |->
			result_o.reads == 6'h04 && result_o.writes == 6'h07;
	endproperty
	a_fault: assert property (p_fault) else $error("fault entry bus count");
	property p_int;
		int_ack_cycle_o |-> bus_rd_o && busy_q && rq_q.op == OP_EXC_INTERRUPT;
	endproperty
	a_int: assert property (p_int) else $error("acknowledge outside entry");
	// Waits may only stretch a cycle, never shorten it
	property p_rdlen;
		$rose(bus_rd_o) |-> bus_rd_o [*4];
	endproperty
	a_rdlen: assert property (p_rdlen) else $error("read cycle too short");

endmodule // instruction_cycle_timing_asserts

bind instruction_cycle_timing instruction_cycle_timing_asserts u_asserts (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
	.req_ready_o(req_ready_o), .req_i(req_i), .bus_rd_o(bus_rd_o),
	.bus_wr_o(bus_wr_o), .int_ack_cycle_o(int_ack_cycle_o),
	.bus_ack_pin_i(bus_ack_pin_i), .halted_o(halted_o),
	.resume_pin_i(resume_pin_i), .done_o(done_o), .result_o(result_o)
);

`default_nettype wire

// >>> bus_partner.sv
`timescale 1ns/1ps
`default_nettype none

module bus_partner (
	// Clock and reset
	input wire logic	core_clk_i,
	input wire logic	rst_i,
	// Bus strobes and mode
	input wire logic	bus_rd_i,
	input wire logic	bus_wr_i,
	input wire logic	slow_i,
	// Acknowledge pin
	output logic		ack_o
);
	// ----------------------------------------
	// Answer timing
	// ----------------------------------------
	logic [3:0] act_q;

	always_ff @(posedge core_clk_i) begin
		if (rst_i || !(bus_rd_i || bus_wr_i)) begin
			act_q <= 4'h0;
		end else if (act_q != 4'hF) begin
			act_q <= act_q + 4'h1;
		end
	end

	// Slow mode holds off eight clocks, so the first cycle gains waits
	assign ack_o = (bus_rd_i || bus_wr_i) && (!slow_i || act_q > 4'h7);

endmodule // bus_partner

`default_nettype wire

// >>> instruction_cycle_timing_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module instruction_cycle_timing_tb_top;
	import cycle_timing_pkg::*;

	logic		core_clk_i, rst_i, req_valid_i, resume_pin_i, ack;
	logic		req_ready_o, bus_rd_o, bus_wr_o, int_ack_cycle_o, halted_o, done_o;
	instr_req_s	req_i;
	cost_s		result_o;
	logic		slow_mode;
	int		error_cnt, check_count;

	instruction_cycle_timing u_dut (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
		.req_ready_o(req_ready_o), .req_i(req_i), .bus_rd_o(bus_rd_o),
		.bus_wr_o(bus_wr_o), .int_ack_cycle_o(int_ack_cycle_o),
		.bus_ack_pin_i(ack), .halted_o(halted_o), .resume_pin_i(resume_pin_i),
		.done_o(done_o), .result_o(result_o)
	);

	bus_partner u_mem (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .bus_rd_i(bus_rd_o),
		.bus_wr_i(bus_wr_o), .slow_i(slow_mode), .ack_o(ack)
	);

	// ----------------------------------------
	// Checks and one transfer
	// ----------------------------------------
	task automatic stop_test();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [21:0] g, input logic [21:0] e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Called at a falling edge; returns in the done cycle, so calls run back to back
	task automatic x(input op_e o, input mode_e m, input logic [5:0] f, input logic [4:0] n,
			input logic [9:0] k, input logic [5:0] rd, input logic [5:0] wr);
		instr_req_s r;
		cost_s e;
		int t, b, ia, g, w;
		r.op = o;
		r.mode = m;
		{r.size_long, r.disp_word, r.cond_true, r.count_expired, r.to_memory, r.index_long} = f;
		r.reg_count = n;
		r.ea_cost = '{10'h006, 6'h01, 6'h00};
		e = '{k, rd, wr};
		b = 0;
		ia = 0;
		g = 0;
		req_i = r;
		req_valid_i = 1'b1;
		while (req_ready_o !== 1'b1 && g < 50) begin
			@(negedge core_clk_i);
			g++;
		end
		@(negedge core_clk_i);
		req_valid_i = 1'b0;
		t = 1;
		while (done_o !== 1'b1 && t < 2000) begin
			b += (bus_rd_o === 1'b1) + (bus_wr_o === 1'b1);
			ia += (int_ack_cycle_o === 1'b1);
			resume_pin_i = (halted_o === 1'b1);
			@(negedge core_clk_i);
			t++;
		end
		resume_pin_i = 1'b0;
		if (t >= 2000 || g >= 50) begin
			error_cnt++;
			$display("MISMATCH %0t no completion", $time);
			stop_test();
		end
		// Slow partner acks after eight clocks plus two sync stages: seven waits per burst
		w = slow_mode ? 7 : 0;
		e.clocks = 10'(k + w);
		chk(22'(b), 22'(4 * (rd + wr) + w));
		if (o == OP_EXC_INTERRUPT) chk(22'(ia), 22'(4 + w));
		chk(result_o, e);
		if (o != OP_HALT_WAIT) chk(22'(t - 1), 22'(e.clocks));
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_branch();
		x(OP_COND_BRANCH, AM_IND, 6'h08, 5'h0, 10'hA, 6'h2, 6'h0);
		x(OP_COND_BRANCH, AM_IND, 6'h00, 5'h0, 10'h8, 6'h1, 6'h0);
		x(OP_COND_BRANCH, AM_IND, 6'h10, 5'h0, 10'hC, 6'h2, 6'h0);
		x(OP_BRANCH_ALWAYS, AM_IND, 6'h10, 5'h0, 10'hA, 6'h2, 6'h0);
		x(OP_BRANCH_TO_SUB, AM_IND, 6'h00, 5'h0, 10'h12, 6'h2, 6'h2);
		x(OP_DEC_BRANCH, AM_IND, 6'h08, 5'h0, 10'hC, 6'h2, 6'h0);
		x(OP_DEC_BRANCH, AM_IND, 6'h00, 5'h0, 10'hA, 6'h2, 6'h0);
		x(OP_DEC_BRANCH, AM_IND, 6'h04, 5'h0, 10'hE, 6'h3, 6'h0);
		x(OP_SW_VECTOR, AM_IND, 6'h00, 5'h0, 10'h22, 6'h4, 6'h3);
		x(OP_OVERFLOW_CALL, AM_IND, 6'h08, 5'h0, 10'h22, 6'h5, 6'h3);
		x(OP_OVERFLOW_CALL, AM_IND, 6'h00, 5'h0, 10'h4, 6'h1, 6'h0);
	endtask

	task automatic t_jump();
		x(OP_JUMP, AM_IND, 6'h00, 5'h0, 10'h8, 6'h2, 6'h0);
		x(OP_JUMP, AM_DISP, 6'h00, 5'h0, 10'hA, 6'h2, 6'h0);
		x(OP_JUMP, AM_INDEXED, 6'h00, 5'h0, 10'hE, 6'h2, 6'h0);
		x(OP_JUMP, AM_INDEXED, 6'h01, 5'h0, 10'hE, 6'h2, 6'h0);
		x(OP_JUMP, AM_ABS_LONG, 6'h00, 5'h0, 10'hC, 6'h3, 6'h0);
		x(OP_SUB_JUMP, AM_IND, 6'h00, 5'h0, 10'h10, 6'h2, 6'h2);
		x(OP_SUB_JUMP, AM_INDEXED, 6'h01, 5'h0, 10'h16, 6'h2, 6'h2);
		x(OP_SUB_JUMP, AM_ABS_LONG, 6'h00, 5'h0, 10'h14, 6'h3, 6'h2);
		x(OP_ADDR_LOAD, AM_IND, 6'h00, 5'h0, 10'h4, 6'h1, 6'h0);
		x(OP_ADDR_PUSH, AM_IND, 6'h00, 5'h0, 10'hC, 6'h1, 6'h2);
		x(OP_ADDR_PUSH, AM_DISP, 6'h00, 5'h0, 10'h10, 6'h2, 6'h2);
		x(OP_ADDR_PUSH, AM_INDEXED, 6'h01, 5'h0, 10'h14, 6'h2, 6'h2);
	endtask

	task automatic t_multi();
		x(OP_MULTI_MOVE, AM_IND, 6'h00, 5'h3, 10'h18, 6'h6, 6'h0);
		x(OP_MULTI_MOVE, AM_ABS_LONG, 6'h20, 5'h2, 10'h24, 6'h9, 6'h0);
		x(OP_MULTI_MOVE, AM_PREDEC, 6'h02, 5'h4, 10'h1C, 6'h2, 6'h4);
		x(OP_MULTI_MOVE, AM_DISP, 6'h22, 5'h10, 10'hAC, 6'h3, 6'h20);
		x(OP_MULTI_MOVE, AM_IND, 6'h02, 5'h0, 10'h8, 6'h2, 6'h0);
	endtask

	task automatic t_prec();
		x(OP_EXT_ADD, AM_REG_DIRECT, 6'h00, 5'h0, 10'h4, 6'h1, 6'h0);
		x(OP_EXT_ADD, AM_REG_DIRECT, 6'h20, 5'h0, 10'h8, 6'h1, 6'h0);
		x(OP_EXT_SUB, AM_PREDEC, 6'h00, 5'h0, 10'h12, 6'h3, 6'h1);
		x(OP_EXT_SUB, AM_PREDEC, 6'h20, 5'h0, 10'h1E, 6'h5, 6'h2);
		x(OP_MEM_COMPARE, AM_POSTINC, 6'h00, 5'h0, 10'hC, 6'h3, 6'h0);
		x(OP_MEM_COMPARE, AM_POSTINC, 6'h20, 5'h0, 10'h14, 6'h5, 6'h0);
		x(OP_DEC_ADD, AM_REG_DIRECT, 6'h00, 5'h0, 10'h6, 6'h1, 6'h0);
		x(OP_DEC_SUB, AM_PREDEC, 6'h00, 5'h0, 10'h12, 6'h3, 6'h1);
	endtask

	task automatic t_misc();
		for (int i = 0; i < 3; i++) begin
			x(op_e'(OP_STATUS_AND + i), AM_IND, 6'h00, 5'h0, 10'h14, 6'h3, 6'h0);
		end
		x(OP_LOAD_STATUS, AM_REG_DIRECT, 6'h00, 5'h0, 10'hC, 6'h2, 6'h0);
		x(OP_LOAD_STATUS, AM_DISP, 6'h00, 5'h0, 10'h12, 6'h3, 6'h0);
		x(OP_SUB_RETURN, AM_IND, 6'h00, 5'h0, 10'h10, 6'h4, 6'h0);
		x(OP_PERIPH_MOVE, AM_IND, 6'h02, 5'h0, 10'h10, 6'h2, 6'h2);
		x(OP_PERIPH_MOVE, AM_IND, 6'h22, 5'h0, 10'h18, 6'h2, 6'h4);
		x(OP_PERIPH_MOVE, AM_IND, 6'h00, 5'h0, 10'h10, 6'h4, 6'h0);
		x(OP_PERIPH_MOVE, AM_IND, 6'h20, 5'h0, 10'h18, 6'h6, 6'h0);
		x(OP_HALT_WAIT, AM_IND, 6'h00, 5'h0, 10'h4, 6'h0, 6'h0);
	endtask

	task automatic t_exc();
		for (int i = 0; i < 2; i++) begin
			x(op_e'(OP_EXC_ADDRESS + i), AM_IND, 6'h00, 5'h0, 10'h32, 6'h4, 6'h7);
		end
		for (int i = 0; i < 3; i++) begin
			x(op_e'(OP_EXC_ILLEGAL + i), AM_IND, 6'h00, 5'h0, 10'h22, 6'h4, 6'h3);
		end
		x(OP_EXC_INTERRUPT, AM_IND, 6'h00, 5'h0, 10'h2C, 6'h5, 6'h3);
	endtask

	// Late acknowledge: counts stay, clocks grow by the waits
	task automatic t_slow();
		slow_mode = 1'b1;
		x(OP_EXC_INTERRUPT, AM_IND, 6'h00, 5'h0, 10'h2C, 6'h5, 6'h3);
		x(OP_BRANCH_TO_SUB, AM_IND, 6'h00, 5'h0, 10'h12, 6'h2, 6'h2);
		slow_mode = 1'b0;
	endtask

	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	initial begin
		error_cnt = 0;
		check_count = 0;
		rst_i = 1'b1;
		req_valid_i = 1'b0;
		resume_pin_i = 1'b0;
		slow_mode = 1'b0;
		req_i = '0;
		repeat (10) @(negedge core_clk_i);
		rst_i = 1'b0;
		chk({req_ready_o, bus_rd_o, bus_wr_o, halted_o, done_o, 17'h0}, {1'b1, 21'h0});
		chk(result_o, 22'h0);
		t_branch();
		t_jump();
		t_multi();
		t_prec();
		t_misc();
		t_exc();
		t_slow();
		stop_test();
	end

endmodule // instruction_cycle_timing_tb_top

`default_nettype wire
